//--- rtl/eic_defines.vh
// constants for the external interrupt channel 3/4 configuration block
`ifndef EIC_DEFINES_VH
`define EIC_DEFINES_VH

// ==========================================================
// register offsets
`define EIC_ADDR_W        12
`define EIC_ADDR_CFG3     12'hfda
`define EIC_ADDR_CFG4     12'hfdb
`define EIC_ADDR_STATUS   12'hfdc
`define EIC_ADDR_MASK     12'hfdd

// ==========================================================
// field positions in a channel config register
`define EIC_LVL_BIT       4
`define EIC_ES_HI         3
`define EIC_ES_LO         2
`define EIC_NC_HI         1
`define EIC_NC_LO         0

// ==========================================================
// reset values
`define EIC_CFG_RESET     8'h00
`define EIC_STAT_RESET    2'h0
`define EIC_MASK_RESET    2'h0
`define EIC_ES_RESET      2'h0
`define EIC_NC_RESET      2'h0
`define EIC_LVL_RESET     1'h0

// ==========================================================
// edge select codes
`define EIC_ES_RISE       2'h0
`define EIC_ES_FALL       2'h1
`define EIC_ES_BOTH       2'h2
`define EIC_ES_HIGH       2'h3

// ==========================================================
// sample interval codes and gear and low clock divider terminal counts
`define EIC_NC_DIV1       2'h0
`define EIC_NC_DIV4       2'h1
`define EIC_NC_DIV8       2'h2
`define EIC_NC_DIV16      2'h3
`define EIC_DIV4_LAST     4'h3
`define EIC_DIV8_LAST     4'h7
`define EIC_DIV16_LAST    4'hf
`define EIC_LF_DIV_LAST   2'h3

`endif

//--- rtl/eic_tick_gen.v
// gear clock divider and low-frequency clock divided by four
`timescale 1ns/1ps
`include "eic_defines.vh"

module eic_tick_gen (
  // clock and reset
  input  wire       i_sys_clk,
  input  wire       i_rst_n,
  // low-frequency clock pin
  input  wire       i_low_freq_clock,
  // divider state and slow tick
  output reg  [3:0] o_gear_cnt,
  output reg        o_slow_tick
);

  // ==========================================================
  // low-frequency clock synchroniser and edge
  reg       lf_meta_r;   // first stage
  reg       lf_sync_r;   // second stage
  reg       lf_prev_r;   // previous synced level
  reg [1:0] lf_cnt_r;    // fs edge counter

  // sync, count fs edges, pulse every fourth
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lf_meta_r   <= 1'b0;
      lf_sync_r   <= 1'b0;
      lf_prev_r   <= 1'b0;
      lf_cnt_r    <= 2'h0;
      o_slow_tick <= 1'b0;
      o_gear_cnt  <= 4'h0;
    end else begin
      lf_meta_r   <= i_low_freq_clock;
      lf_sync_r   <= lf_meta_r;
      lf_prev_r   <= lf_sync_r;
      o_gear_cnt  <= o_gear_cnt + 4'h1;
      o_slow_tick <= 1'b0;
      if (lf_sync_r && !lf_prev_r) begin
        // rising fs edge
        lf_cnt_r <= lf_cnt_r + 2'h1;
        if (lf_cnt_r == `EIC_LF_DIV_LAST) begin
          o_slow_tick <= 1'b1;
        end
      end
    end
  end

endmodule // eic_tick_gen

//--- rtl/eic_noise_filter.v
// sampling noise canceller for one synchronised pin
`timescale 1ns/1ps
`include "eic_defines.vh"

module eic_noise_filter (
  // clock and reset
  input  wire i_sys_clk,
  input  wire i_rst_n,
  // sampling control
  input  wire i_sample_tick,
  input  wire i_low_speed,
  // synchronised pin level
  input  wire i_pin,
  // filtered level
  output reg  o_level
);

  // ==========================================================
  // sample history
  reg [2:0] hist_r;      // newest sample in bit 0
  reg [2:0] hist_nxt;    // history after this tick

  // shift a sample in on each tick, pass stable levels
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hist_r  <= 3'h0;
      o_level <= 1'b0;
    end else if (i_sample_tick) begin
      hist_r <= hist_nxt;
      if (i_low_speed) begin
        // two equal samples suffice
        if (hist_nxt[1] == hist_nxt[0]) begin
          o_level <= hist_nxt[0]; // [R15]
        end
      end else if ((hist_nxt == 3'h7) || (hist_nxt == 3'h0)) begin
        // three equal samples needed
        o_level <= hist_nxt[0]; // [R14]
      end
    end
  end

  // next history word
  always @* begin
    hist_nxt = {hist_r[1:0], i_pin};
  end

endmodule // eic_noise_filter

//--- rtl/eic_top.v
// external interrupt channels 3 and 4: filters, edge logic, registers
//
// Operation
// [R1] lvl bit4, edge 3:2, interval 1:0, reset zero
// [R2] bits 7:5 read zero, writes ignored
// [R3] ch3: 01 falling, 10 both edges
// [R4] ch4: 00 rise, 01 fall, 10 both, 11 high
// [R5] fast modes: interval selects gear divide 1/4/8/16
// [R6] slow modes: sample at low clock over four
// [R7] captured level reloaded on every request
// [R8] software disables enable before mode change
// [R9] software waits twelve fs after slowing down
// [R10] software waits 2 gear plus 3 samples
// [R11] software disables enable before config write
// [R12] only these channels have configurable fields
// [R13] ch3: 00 rising edge, 11 reserved
// [R14] fast modes: three equal samples pass level
// [R15] slow modes: two equal samples pass level
// [R16] ch4 high mode: request each sample while high
`timescale 1ns/1ps
`include "eic_defines.vh"

module eic_top (
  // clock and reset
  input  wire                   i_sys_clk,
  input  wire                   i_nrst,
  // register port
  input  wire [`EIC_ADDR_W-1:0] i_addr,
  input  wire [7:0]             i_wdata,
  input  wire                   i_wr,
  input  wire                   i_rd,
  output reg  [7:0]             o_rdata,
  // operating mode, high in slow or sleep
  input  wire                   i_low_speed_mode,
  // pins and low-frequency clock
  input  wire                   i_chan3_pin,
  input  wire                   i_chan4_pin,
  input  wire                   i_low_freq_clock,
  // request pulses to the interrupt latch
  output reg                    o_chan3_req,
  output reg                    o_chan4_req,
  // level interrupt
  output reg                    o_irq
);

  // ==========================================================
  // reset release
  // assert at once, release only on a clock edge, so no flop
  // leaves reset in a different cycle from its neighbours
  reg rst_meta_r;   // first release stage
  reg rst_n_r;      // reset used by the design

  // two flops release the asynchronous reset
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ==========================================================
  // pin synchronisers
  // pins are board signals with no timing to this clock;
  // the first stage may go metastable, only stage two is read
  reg [1:0] pin_meta_r;   // first stage, ch4 in bit 1
  reg [1:0] pin_sync_r;   // second stage

  // two flops before any logic sees the pins
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pin_meta_r <= 2'h0;
      pin_sync_r <= 2'h0;
    end else begin
      pin_meta_r <= {i_chan4_pin, i_chan3_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ==========================================================
  // config and interrupt registers
  reg [1:0] es3_r;     // chan3_edge_select
  reg [1:0] nc3_r;     // chan3_sample_interval
  reg       lvl3_r;    // chan3_captured_level
  reg [1:0] es4_r;     // chan4_edge_select
  reg [1:0] nc4_r;     // chan4_sample_interval
  reg       lvl4_r;    // chan4_captured_level
  reg [1:0] stat_r;    // sticky request status
  reg [1:0] mask_r;    // interrupt mask

  // ==========================================================
  // sample timing
  wire [3:0] gear_cnt;    // free gear divider
  wire       slow_tick;   // low clock over four

  // shared divider for both channels
  // one divider keeps the ticks of both channels aligned
  eic_tick_gen u_tick (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (rst_n_r),
    .i_low_freq_clock (i_low_freq_clock),
    .o_gear_cnt       (gear_cnt),
    .o_slow_tick      (slow_tick)
  );

  // pick the sample tick for one channel
  // fast modes: low counter bits all ones mark a tick
  // slow modes: one tick per four low clock rising edges
  function sel_tick;
    input [1:0] nc;
    input [3:0] cnt;
    input       low;
    input       stick;
    begin
      if (low) begin
        // interval code ignored
        sel_tick = stick; // [R6]
      end else begin
        case (nc) // [R5]
          `EIC_NC_DIV1:  sel_tick = 1'b1;
          `EIC_NC_DIV4:  sel_tick = ({2'h0, cnt[1:0]} == `EIC_DIV4_LAST);
          `EIC_NC_DIV8:  sel_tick = ({1'h0, cnt[2:0]} == `EIC_DIV8_LAST);
          `EIC_NC_DIV16: sel_tick = (cnt == `EIC_DIV16_LAST);
          default:       sel_tick = 1'b0;
        endcase
      end
    end
  endfunction

  wire tick3;   // ch3 sample tick
  wire tick4;   // ch4 sample tick

  assign tick3 = sel_tick(nc3_r, gear_cnt, i_low_speed_mode, slow_tick);
  assign tick4 = sel_tick(nc4_r, gear_cnt, i_low_speed_mode, slow_tick);

  // ==========================================================
  // noise cancellers
  wire lev3;   // ch3 filtered level
  wire lev4;   // ch4 filtered level

  // each filter has its own tick, the mode is shared
  // channel 3 filter
  eic_noise_filter u_filt3 (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (rst_n_r),
    .i_sample_tick (tick3),
    .i_low_speed   (i_low_speed_mode),
    .i_pin         (pin_sync_r[0]),
    .o_level       (lev3)
  );

  // channel 4 filter
  eic_noise_filter u_filt4 (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (rst_n_r),
    .i_sample_tick (tick4),
    .i_low_speed   (i_low_speed_mode),
    .i_pin         (pin_sync_r[1]),
    .o_level       (lev4)
  );

  // ==========================================================
  // edge detection
  reg  prev3_r;   // ch3 last filtered level
  reg  prev4_r;   // ch4 last filtered level

  // prev flops reset low like the filter output, so an
  // idle low pin gives no false edge after reset
  // remember filtered levels
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      prev3_r <= 1'b0;
      prev4_r <= 1'b0;
    end else begin
      prev3_r <= lev3;
      prev4_r <= lev4;
    end
  end

  // edge condition shared by both channels
  function edge_hit;
    input [1:0] es;
    input       cur;
    input       prev;
    begin
      case (es)
        `EIC_ES_RISE: edge_hit = cur & ~prev;
        `EIC_ES_FALL: edge_hit = ~cur & prev;
        `EIC_ES_BOTH: edge_hit = cur ^ prev;
        default:      edge_hit = 1'b0;
      endcase
    end
  endfunction

  reg req3_nxt;   // ch3 request this cycle
  reg req4_nxt;   // ch4 request this cycle

  // request conditions
  // ch4 high mode follows the tick, not an edge, so a held
  // level requests once per sample interval
  always @* begin
    // ch3: code 11 reserved, never requests
    req3_nxt = edge_hit(es3_r, lev3, prev3_r); // [R3] [R13]
    if (es4_r == `EIC_ES_HIGH) begin
      // repeat on every sample while high
      req4_nxt = tick4 & lev4; // [R4] [R16]
    end else begin
      req4_nxt = edge_hit(es4_r, lev4, prev4_r); // [R4]
    end
  end

  // ==========================================================
  // register port decode
  // only channels 3 and 4 carry config fields here; the
  // fixed channels have nothing to configure and are not mapped
  wire wr3;    // write to ext_irq3_config
  wire wr4;    // write to ext_irq4_config
  wire wrst;   // write to status
  wire wrmk;   // write to mask

  assign wr3  = i_wr && (i_addr == `EIC_ADDR_CFG3); // [R12]
  assign wr4  = i_wr && (i_addr == `EIC_ADDR_CFG4); // [R12]
  assign wrst = i_wr && (i_addr == `EIC_ADDR_STATUS);
  assign wrmk = i_wr && (i_addr == `EIC_ADDR_MASK);

  // writable config fields, upper bits dropped
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      es3_r <= `EIC_ES_RESET; // [R1]
      nc3_r <= `EIC_NC_RESET; // [R1]
      es4_r <= `EIC_ES_RESET; // [R1]
      nc4_r <= `EIC_NC_RESET; // [R1]
    end else begin
      if (wr3) begin
        // bits 7:5 and 4 not stored
        es3_r <= i_wdata[`EIC_ES_HI:`EIC_ES_LO]; // [R1] [R2]
        nc3_r <= i_wdata[`EIC_NC_HI:`EIC_NC_LO]; // [R1]
      end
      if (wr4) begin
        // same layout as channel 3
        es4_r <= i_wdata[`EIC_ES_HI:`EIC_ES_LO]; // [R1] [R2]
        nc4_r <= i_wdata[`EIC_NC_HI:`EIC_NC_LO]; // [R1]
      end
    end
  end

  // captured levels, read only
  // loaded at the status edge, so a read after the interrupt
  // shows the level that caused it
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      lvl3_r <= `EIC_LVL_RESET; // [R1]
      lvl4_r <= `EIC_LVL_RESET; // [R1]
    end else begin
      if (req3_nxt) begin
        // channel 3 request this cycle
        lvl3_r <= lev3; // [R7]
      end
      if (req4_nxt) begin
        // channel 4 request this cycle
        lvl4_r <= lev4; // [R7]
      end
    end
  end

  // ==========================================================
  // sticky status and mask
  reg [1:0] stat_nxt;   // status after set and clear

  // write one clears, a new request wins
  // so an event that meets its own clear is never lost
  always @* begin
    stat_nxt = stat_r;
    if (wrst) begin
      stat_nxt = stat_r & ~i_wdata[1:0];
    end
    stat_nxt = stat_nxt | {req4_nxt, req3_nxt};
  end

  // status, mask, request and interrupt flops
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stat_r      <= `EIC_STAT_RESET;
      mask_r      <= `EIC_MASK_RESET;
      o_chan3_req <= 1'b0;
      o_chan4_req <= 1'b0;
      o_irq       <= 1'b0;
    end else begin
      stat_r      <= stat_nxt;
      if (wrmk) begin
        // plain read-write mask
        mask_r <= i_wdata[1:0];
      end
      o_chan3_req <= req3_nxt;
      o_chan4_req <= req4_nxt;
      // level, follows status and mask
      // a mask written this cycle already counts
      o_irq       <= |(stat_nxt & (wrmk ? i_wdata[1:0] : mask_r));
    end
  end

  // ==========================================================
  // read data
  reg [7:0] rd_nxt;   // selected read word

  // unmapped addresses read zero
  always @* begin
    rd_nxt = 8'h00;
    case (i_addr)
      `EIC_ADDR_CFG3: begin
        // upper bits stay zero
        rd_nxt = {3'h0, lvl3_r, es3_r, nc3_r}; // [R1] [R2]
      end
      `EIC_ADDR_CFG4: begin
        rd_nxt = {3'h0, lvl4_r, es4_r, nc4_r}; // [R1] [R2]
      end
      `EIC_ADDR_STATUS: begin
        rd_nxt = {6'h00, stat_r};
      end
      `EIC_ADDR_MASK: begin
        rd_nxt = {6'h00, mask_r};
      end
      default: begin
        // unmapped, fixed channels included
        rd_nxt = 8'h00; // [R12]
      end
    endcase
  end

  // read data for one cycle after the strobe
  // zero otherwise, keeping the bus quiet between reads
  always @(posedge i_sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      // strobe seen, present the word
      o_rdata <= rd_nxt;
    end else begin
      // no strobe, drive zero
      o_rdata <= 8'h00;
    end
  end

endmodule // eic_top

//--- tb/eic_props.sv
// assertion checker for the channel 3/4 interrupt block
`timescale 1ns/1ps
`include "eic_defines.vh"
module eic_props (
  // clock, reset, register port
  input wire                   i_sys_clk,
  input wire                   i_nrst,
  input wire [`EIC_ADDR_W-1:0] i_addr,
  input wire [7:0]             i_wdata,
  input wire                   i_wr,
  input wire                   i_rd,
  input wire [7:0]             o_rdata,
  // mode, pins, requests
  input wire                   i_low_speed_mode,
  input wire                   i_chan3_pin,
  input wire                   i_chan4_pin,
  input wire                   o_chan3_req,
  input wire                   o_chan4_req,
  input wire                   o_irq
);
  // ====
  // shadow config and settle counters
  reg [3:0] c3_r;  // ch3 edge and interval
  reg [3:0] c4_r;  // ch4 edge and interval
  reg [3:0] ok3_r; // cycles fast, ch3 rise, nc 00
  reg [3:0] ok4_r; // cycles fast, ch4 high, nc 00
  wire      w3 = i_wr && i_addr == `EIC_ADDR_CFG3;
  wire      w4 = i_wr && i_addr == `EIC_ADDR_CFG4;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      c3_r <= 4'h0;
      c4_r <= 4'h0;
      ok3_r <= 4'h0;
      ok4_r <= 4'h0;
    end else begin
      if (w3) c3_r <= i_wdata[3:0];
      if (w4) c4_r <= i_wdata[3:0];
      ok3_r <= (w3 || i_low_speed_mode || c3_r != 4'h0) ? 4'h0
             : ok3_r + {3'h0, ok3_r != 4'hf};
      ok4_r <= (w4 || i_low_speed_mode || c4_r != 4'hc) ? 4'h0
             : ok4_r + {3'h0, ok4_r != 4'hf};
    end
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  // ====
  // properties
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_top;
    $past(i_rd) |-> o_rdata[7:5] == 3'h0;
  endproperty
  a_rd_top: assert property (p_rd_top) else $error("upper bits not zero");
  property p_pulse3;
    o_chan3_req |=> !o_chan3_req;
  endproperty
  a_pulse3: assert property (p_pulse3) else $error("ch3 request too long");
  property p_resv3;
    c3_r[3:2] == 2'h3 && $past(c3_r[3:2]) == 2'h3 |-> !o_chan3_req;
  endproperty
  a_resv3: assert property (p_resv3) else $error("ch3 reserved code fired");
  property p_glitch3;
    ok3_r == 4'hf && o_chan3_req |-> $past(i_chan3_pin, 4) && $past(i_chan3_pin, 5);
  endproperty
  a_glitch3: assert property (p_glitch3) else $error("ch3 rise without level");
  property p_high4;
    (ok4_r == 4'hf && i_chan4_pin) [*6] |-> ##3 o_chan4_req;
  endproperty
  a_high4: assert property (p_high4) else $error("ch4 high mode silent");
  property p_irq_up;
    $rose(o_irq) |-> $past(i_wr) || o_chan3_req || o_chan4_req;
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq rose without cause");
  property p_irq_dn;
    $fell(o_irq) |-> $past(i_wr);
  endproperty
  a_irq_dn: assert property (p_irq_dn) else $error("irq fell without write");
endmodule // eic_props

bind eic_top eic_props u_props (
  .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_low_speed_mode(i_low_speed_mode),
  .i_chan3_pin(i_chan3_pin), .i_chan4_pin(i_chan4_pin), .o_chan3_req(o_chan3_req),
  .o_chan4_req(o_chan4_req), .o_irq(o_irq));

//--- tb/eic_pin_model.sv
// board side: pin drivers and free low-frequency oscillator
`timescale 1ns/1ps
module eic_pin_model (
  // commanded levels
  input  wire i_lvl3,
  input  wire i_lvl4,
  // pins and oscillator
  output reg  o_pin3,
  output reg  o_pin4,
  output reg  o_lf_clk
);
  // pins lag the command, unrelated to the system clock
  initial begin
    o_pin3 = 1'b0;
    o_pin4 = 1'b0;
    o_lf_clk = 1'b0;
  end
  always @(i_lvl3) o_pin3 <= #7 i_lvl3;
  always @(i_lvl4) o_pin4 <= #7 i_lvl4;
  // oscillator runs free, ten system cycles a period
  always #200 o_lf_clk = ~o_lf_clk;
endmodule // eic_pin_model

//--- tb/eic_top_tb_top.sv
// self-checking bench for the channel 3/4 interrupt block
`timescale 1ns/1ps
module eic_top_tb_top;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [11:0] addr = 12'h000;
  reg  [7:0]  wdata = 8'h00;
  reg         wr = 1'b0;
  reg         rd = 1'b0;
  reg         mode = 1'b0;
  reg         lvl3 = 1'b0;
  reg         lvl4 = 1'b0;
  wire [7:0]  rdata;
  wire        req3, req4, irq, pin3, pin4, lfc;
  integer     n3 = 0, n4 = 0, bad_count = 0, checked = 0;
  integer     i, c, a3, a4, dv;

  initial begin
    forever #20 clk = ~clk;
  end
  // running request counts
  always @(posedge clk) begin
    n3 <= n3 + req3;
    n4 <= n4 + req4;
  end

  eic_pin_model u_pins (.i_lvl3(lvl3), .i_lvl4(lvl4), .o_pin3(pin3), .o_pin4(pin4),
    .o_lf_clk(lfc));
  eic_top uut (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_low_speed_mode(mode),
    .i_chan3_pin(pin3), .i_chan4_pin(pin4), .i_low_freq_clock(lfc),
    .o_chan3_req(req3), .o_chan4_req(req4), .o_irq(irq));

  // ====
  // tasks
  task cmp(input string nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr_reg(input [11:0] a, input [7:0] v);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rchk(input [11:0] a, input [7:0] e);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      cmp("rdata", e, rdata);
    end
  endtask
  task irqc(input e);
    begin
      #1;
      cmp("irq", {7'h0, e}, {7'h0, irq});
    end
  endtask
  task win;
    begin
      a3 = n3;
      a4 = n4;
      repeat (24) @(posedge clk);
      #1;
      a3 = n3 - a3;
      a4 = n4 - a4;
      if (a3 > 2) a3 = 2;
      if (a4 > 2) a4 = 2;
    end
  endtask
  task lat;
    begin
      @(posedge clk);
      lvl3 <= ~lvl3;
      c = 0;
      while (req3 !== 1'b1 && c < 300) begin
        @(posedge clk);
        #1;
        c = c + 1;
      end
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask

  // ====
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(12'hfda, 8'h00);
    rchk(12'hfdb, 8'h00);
    wr_reg(12'hfda, 8'hff);
    rchk(12'hfda, 8'h0f);
    wr_reg(12'hfdb, 8'he3);
    rchk(12'hfdb, 8'h03);
    rchk(12'h123, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr_reg(12'hfda, {4'h0, i[1:0], 2'h0});
      wr_reg(12'hfdb, {4'h0, i[1:0], 2'h0});
      win;
      @(posedge clk);
      lvl3 <= 1'b1;
      lvl4 <= 1'b1;
      win;
      cmp("rise3", i % 2 == 0, a3);
      cmp("rise4", i == 3 ? 2 : i % 2 == 0, a4);
      rchk(12'hfda, {3'h0, i != 3, i[1:0], 2'h0});
      rchk(12'hfdb, {4'h1, i[1:0], 2'h0});
      @(posedge clk);
      lvl3 <= 1'b0;
      lvl4 <= 1'b0;
      win;
      cmp("fall3", i == 1 || i == 2, a3);
      cmp("fall4", i == 3 ? 2 : i == 1 || i == 2, a4);
      rchk(12'hfda, {3'h0, i == 0, i[1:0], 2'h0});
      rchk(12'hfdb, {3'h0, i == 0 || i == 3, i[1:0], 2'h0});
      win;
      cmp("quiet4", 0, a4);
    end
    rchk(12'hfdc, 8'h03);
    wr_reg(12'hfdd, 8'h01);
    irqc(1'b1);
    wr_reg(12'hfdd, 8'h00);
    irqc(1'b0);
    wr_reg(12'hfdc, 8'h01);
    wr_reg(12'hfdd, 8'h01);
    irqc(1'b0);
    rchk(12'hfdc, 8'h02);
    rchk(12'hfdd, 8'h01);
    wr_reg(12'hfda, 8'h08);
    @(posedge clk);
    lvl3 <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    lvl3 <= 1'b0;
    win;
    cmp("glitch", 0, a3);
    for (i = 0; i < 4; i = i + 1) begin
      dv = i == 0 ? 1 : 2 << i;
      wr_reg(12'hfda, {6'h02, i[1:0]});
      repeat (20) @(posedge clk);
      lat;
      cmp("lat", 1, c >= 2 * dv + 2 && c <= 3 * dv + 5);
    end
    wr_reg(12'hfdd, 8'h00);
    wr_reg(12'hfda, 8'h08);
    @(posedge clk);
    mode <= 1'b1;
    repeat (120) @(posedge clk);
    wr_reg(12'hfdc, 8'h03);
    lat;
    cmp("slow", 1, c >= 40 && c <= 88);
    @(posedge clk);
    mode <= 1'b0;
    repeat (60) @(posedge clk);
    wr_reg(12'hfdc, 8'h03);
    lat;
    cmp("fast", 1, c >= 4 && c <= 8);
    end_sim;
  end

  // hang guard
  initial begin
    #800000;
    bad_count = bad_count + 1;
    end_sim;
  end
endmodule // eic_top_tb_top
